/* logic/input_override_occupancy_regs.sv */
`default_nettype none

module input_override_occupancy_regs
   import input_conditioning_pkg::*;
#(
   parameter longint SECOND_CYCLES = SECOND_CYCLES_DF
)
(
   input  wire logic                       clk_i,
   input  wire logic                       nrst_i,
   input  wire logic [SWITCH_COUNT-1:0]    switch_input_i,
   input  wire logic [OCCUPANCY_COUNT-1:0] occupancy_input_i,
   input  wire logic                       bus1_lit_state_i,
   input  wire logic [15:0]                reg_addr_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   input  wire logic [REG_WIDTH-1:0]       reg_wdata_i,
   output logic      [REG_WIDTH-1:0]       reg_rdata_o,
   output logic                            reg_ack_o,
   output logic                            reg_err_o,
   output logic      [SWITCH_COUNT-1:0]    switch_level_o,
   output logic      [SWITCH_COUNT-1:0]    switch_change_o,
   output logic      [OCCUPANCY_COUNT-1:0] occupancy_active_o,
   output logic                            bus1_all_off_strobe_o,
   output logic                            bus1_recall_scene_strobe_o
);

   localparam logic [31:0] SECOND_LAST = 32'(SECOND_CYCLES - 1);

   // Pin synchronisers and the stored previous switch values.
   logic [SWITCH_COUNT-1:0]    sw_meta_ff;
   logic [SWITCH_COUNT-1:0]    sw_sync_ff;
   logic [SWITCH_COUNT-1:0]    sw_prev_ff;
   logic [OCCUPANCY_COUNT-1:0] occ_meta_ff;
   logic [OCCUPANCY_COUNT-1:0] occ_sync_ff;

   // Software-visible registers.
   logic [REG_WIDTH-1:0]       override_ff;
   logic [REG_WIDTH-1:0]       lockout_ff;
   logic [REG_WIDTH-1:0]       contact_type_ff [OCCUPANCY_COUNT];
   logic [REG_WIDTH-1:0]       hold_seconds_ff [OCCUPANCY_COUNT];
   logic                       recall_edge_ff;
   logic                       off_edge_ff;

   // Conditioned switch state and lighting strobes.
   logic [SWITCH_COUNT-1:0]    switch_level_ff;
   logic [SWITCH_COUNT-1:0]    switch_change_ff;
   logic                       all_off_ff;
   logic                       recall_ff;

   // Seconds tick and bus answer.
   logic [31:0]                sec_cnt_ff;
   logic                       tick_ff;
   logic [REG_WIDTH-1:0]       rdata_ff;
   logic                       ack_ff;
   logic                       err_ff;

   // Decode and combinational helpers.
   logic                       hit_override;
   logic                       hit_lockout;
   logic                       hit_command;
   logic [OCCUPANCY_COUNT-1:0] hit_type;
   logic [OCCUPANCY_COUNT-1:0] hit_hold;
   logic                       addr_mapped;
   logic                       addr_writable;
   logic                       wr_ok;
   logic [OCCUPANCY_COUNT-1:0] motion;
   logic [REG_WIDTH-1:0]       nxt_rdata;
   logic                       nxt_all_off;
   logic                       nxt_recall;

   // Switch and occupancy contacts are asynchronous pins, so two flops come first.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sw_meta_ff  <= '0;
         sw_sync_ff  <= '0;
         sw_prev_ff  <= '0;
         occ_meta_ff <= '0;
         occ_sync_ff <= '0;
      end
      else
      begin
         sw_meta_ff  <= switch_input_i;
         sw_sync_ff  <= sw_meta_ff;
         sw_prev_ff  <= sw_sync_ff;
         occ_meta_ff <= occupancy_input_i;
         occ_sync_ff <= occ_meta_ff;
      end
   end

   // Address decode for the register port.
   always_comb
   begin
      hit_override  = (reg_addr_i == SWITCH_INPUT_OVERRIDES_ADDR);
      hit_lockout   = (reg_addr_i == SWITCH_INPUT_LOCKOUT_ADDR);
      hit_command   = (reg_addr_i == LIGHTING_BUS_COMMAND_ADDR);
      hit_type[0]   = (reg_addr_i == OCCUPANCY1_CONTACT_TYPE_ADDR);
      hit_type[1]   = (reg_addr_i == OCCUPANCY2_CONTACT_TYPE_ADDR);
      hit_hold[0]   = (reg_addr_i == OCCUPANCY1_HOLD_SECONDS_ADDR);
      hit_hold[1]   = (reg_addr_i == OCCUPANCY2_HOLD_SECONDS_ADDR);
      addr_writable = hit_override || hit_lockout || hit_command || (|hit_type) || (|hit_hold);
      addr_mapped   = addr_writable
                      || (reg_addr_i == SWITCH_INPUT_LEVELS_ADDR)
                      || (reg_addr_i == OCCUPANCY_RAW_LEVELS_ADDR)
                      || (reg_addr_i == OCCUPANCY_FILTERED_LEVELS_ADDR);
      wr_ok         = reg_wr_i && addr_writable;
   end

   // Switch override and lockout registers; lockout clears to all unblocked.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         override_ff <= OVERRIDE_RESET;
         lockout_ff  <= LOCKOUT_RESET;
      end
      else
      begin
         if (wr_ok && hit_override)
         begin
            override_ff <= {{(REG_WIDTH-SWITCH_COUNT){1'b0}}, reg_wdata_i[SWITCH_COUNT-1:0]};
         end
         if (wr_ok && hit_lockout)
         begin
            lockout_ff <= {{(REG_WIDTH-SWITCH_COUNT){1'b0}}, reg_wdata_i[SWITCH_COUNT-1:0]};
         end
      end
   end

   // Occupancy configuration: contact type and hold seconds per input.
   generate
      for (genvar k = 0; k < OCCUPANCY_COUNT; k++)
      begin : g_occ_cfg
         always_ff @(posedge clk_i or negedge nrst_i)
         begin
            if (!nrst_i)
            begin
               contact_type_ff[k] <= CONTACT_NORM_CLOSED;
               hold_seconds_ff[k] <= HOLD_SECONDS_RESET;
            end
            else
            begin
               if (wr_ok && hit_type[k])
               begin
                  contact_type_ff[k] <= reg_wdata_i;
               end
               if (wr_ok && hit_hold[k])
               begin
                  hold_seconds_ff[k] <= reg_wdata_i;
               end
            end
         end

         // A normally open sensor closes on motion; any other code is taken as normally closed.
         assign motion[k] = (contact_type_ff[k] == CONTACT_NORM_OPEN) ? occ_sync_ff[k] : !occ_sync_ff[k];

         occupancy_hold_timer u_hold
         (
            .clk_i          (clk_i),
            .nrst_i         (nrst_i),
            .motion_i       (motion[k]),
            .tick_i         (tick_ff),
            .hold_seconds_i (hold_seconds_ff[k]),
            .active_o       (occupancy_active_o[k])
         );
      end
   endgenerate

   // Conditioned switch level: the latest of a contact edge or an override write wins; the write wins if both come in one cycle.
   // Both are dropped while the input is locked, so the held level stays put.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         switch_level_ff  <= '0;
         switch_change_ff <= '0;
      end
      else
      begin
         for (int i = 0; i < SWITCH_COUNT; i++)
         begin
            switch_change_ff[i] <= 1'b0;
            if (lockout_ff[i])
            begin
               switch_level_ff[i] <= switch_level_ff[i];
            end
            else if (wr_ok && hit_override)
            begin
               switch_level_ff[i]  <= reg_wdata_i[i];
               switch_change_ff[i] <= reg_wdata_i[i] != switch_level_ff[i];
            end
            else if (sw_sync_ff[i] != sw_prev_ff[i])
            begin
               switch_level_ff[i]  <= sw_sync_ff[i];
               switch_change_ff[i] <= sw_sync_ff[i] != switch_level_ff[i];
            end
         end
      end
   end

   // Lighting command decode. Off takes priority if one write asks for both,
   // which leaves the lights dark rather than racing two frames.
   always_comb
   begin
      nxt_all_off = 1'b0;
      nxt_recall  = 1'b0;
      if (wr_ok && hit_command)
      begin
         if (bus1_lit_state_i && !reg_wdata_i[BUS1_LIT_STATE_BIT])
         begin
            nxt_all_off = 1'b1;
         end
         if (!bus1_lit_state_i && reg_wdata_i[BUS1_LIT_STATE_BIT])
         begin
            nxt_recall = 1'b1;
         end
         if (reg_wdata_i[BUS1_RECALL_EDGE_BIT] && !recall_edge_ff)
         begin
            nxt_recall = 1'b1;
         end
         if (reg_wdata_i[BUS1_OFF_EDGE_BIT] && !off_edge_ff)
         begin
            nxt_all_off = 1'b1;
         end
         if (nxt_all_off)
         begin
            nxt_recall = 1'b0;
         end
      end
   end

   // Edge-command bits are kept so the next write can be compared against them.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         recall_edge_ff <= 1'b0;
         off_edge_ff    <= 1'b0;
         all_off_ff     <= 1'b0;
         recall_ff      <= 1'b0;
      end
      else
      begin
         if (wr_ok && hit_command)
         begin
            recall_edge_ff <= reg_wdata_i[BUS1_RECALL_EDGE_BIT];
            off_edge_ff    <= reg_wdata_i[BUS1_OFF_EDGE_BIT];
         end
         all_off_ff <= nxt_all_off;
         recall_ff  <= nxt_recall;
      end
   end

   // Free-running seconds tick; the count is a parameter so simulation can shorten it.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sec_cnt_ff <= '0;
         tick_ff    <= 1'b0;
      end
      else if (sec_cnt_ff >= SECOND_LAST)
      begin
         sec_cnt_ff <= '0;
         tick_ff    <= 1'b1;
      end
      else
      begin
         sec_cnt_ff <= sec_cnt_ff + 32'h0000_0001;
         tick_ff    <= 1'b0;
      end
   end

   // Read data mux; unused bits read as zero.
   always_comb
   begin
      nxt_rdata = '0;
      case (reg_addr_i)
         SWITCH_INPUT_LEVELS_ADDR:
         begin
            nxt_rdata[SWITCH_COUNT-1:0] = sw_sync_ff;
         end
         OCCUPANCY_RAW_LEVELS_ADDR:
         begin
            nxt_rdata[OCCUPANCY_COUNT-1:0] = occ_sync_ff;
         end
         OCCUPANCY_FILTERED_LEVELS_ADDR:
         begin
            nxt_rdata[OCCUPANCY_COUNT-1:0] = occupancy_active_o;
         end
         SWITCH_INPUT_OVERRIDES_ADDR:
         begin
            nxt_rdata = override_ff;
         end
         SWITCH_INPUT_LOCKOUT_ADDR:
         begin
            nxt_rdata = lockout_ff;
         end
         OCCUPANCY1_CONTACT_TYPE_ADDR:
         begin
            nxt_rdata = contact_type_ff[0];
         end
         OCCUPANCY2_CONTACT_TYPE_ADDR:
         begin
            nxt_rdata = contact_type_ff[1];
         end
         OCCUPANCY1_HOLD_SECONDS_ADDR:
         begin
            nxt_rdata = hold_seconds_ff[0];
         end
         OCCUPANCY2_HOLD_SECONDS_ADDR:
         begin
            nxt_rdata = hold_seconds_ff[1];
         end
         LIGHTING_BUS_COMMAND_ADDR:
         begin
            nxt_rdata[BUS1_LIT_STATE_BIT]   = bus1_lit_state_i;
            nxt_rdata[BUS1_RECALL_EDGE_BIT] = recall_edge_ff;
            nxt_rdata[BUS1_OFF_EDGE_BIT]    = off_edge_ff;
         end
         default:
         begin
            nxt_rdata = '0;
         end
      endcase
   end

   // One-cycle answer for every access; unmapped addresses and writes to
   // read-only registers are refused with the error pulse instead of ack.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rdata_ff <= '0;
         ack_ff   <= 1'b0;
         err_ff   <= 1'b0;
      end
      else
      begin
         ack_ff <= (reg_rd_i && addr_mapped) || wr_ok;
         err_ff <= (reg_rd_i && !addr_mapped) || (reg_wr_i && !addr_writable);
         if (reg_rd_i)
         begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   assign reg_rdata_o                = rdata_ff;
   assign reg_ack_o                  = ack_ff;
   assign reg_err_o                  = err_ff;
   assign switch_level_o             = switch_level_ff;
   assign switch_change_o            = switch_change_ff;
   assign bus1_all_off_strobe_o      = all_off_ff;
   assign bus1_recall_scene_strobe_o = recall_ff;

endmodule // input_override_occupancy_regs

`default_nettype wire

/* include/input_conditioning_pkg.sv */
`default_nettype none

package input_conditioning_pkg;

   // Counts of conditioned inputs.
   localparam int SWITCH_COUNT    = 4;
   localparam int OCCUPANCY_COUNT = 2;
   localparam int REG_WIDTH       = 16;

   // Register offsets on the field-bus register port.
   localparam logic [15:0] SWITCH_INPUT_LEVELS_ADDR       = 16'h7559;
   localparam logic [15:0] OCCUPANCY_RAW_LEVELS_ADDR      = 16'h755B;
   localparam logic [15:0] OCCUPANCY_FILTERED_LEVELS_ADDR = 16'h75C4;
   localparam logic [15:0] SWITCH_INPUT_OVERRIDES_ADDR    = 16'h9CA5;
   localparam logic [15:0] SWITCH_INPUT_LOCKOUT_ADDR      = 16'h9CA6;
   localparam logic [15:0] OCCUPANCY1_CONTACT_TYPE_ADDR   = 16'h9CA7;
   localparam logic [15:0] OCCUPANCY2_CONTACT_TYPE_ADDR   = 16'h9CA8;
   localparam logic [15:0] OCCUPANCY1_HOLD_SECONDS_ADDR   = 16'h9CAB;
   localparam logic [15:0] OCCUPANCY2_HOLD_SECONDS_ADDR   = 16'h9CAC;
   localparam logic [15:0] LIGHTING_BUS_COMMAND_ADDR      = 16'h9D3D;

   // Field positions in the lighting command register.
   localparam int BUS1_LIT_STATE_BIT   = 0;
   localparam int BUS1_RECALL_EDGE_BIT = 1;
   localparam int BUS1_OFF_EDGE_BIT    = 2;

   // Reset values and contact-type codes.
   localparam logic [15:0] LOCKOUT_RESET       = 16'h0000;
   localparam logic [15:0] OVERRIDE_RESET      = 16'h0000;
   localparam logic [15:0] CONTACT_NORM_OPEN   = 16'h0005;
   localparam logic [15:0] CONTACT_NORM_CLOSED = 16'h0006;
   localparam logic [15:0] HOLD_SECONDS_RESET  = 16'h012C;

   // Seconds tick derived from the 50 MHz system clock.
   localparam longint CLK_HZ           = 50_000_000;
   localparam longint SECOND_TICK_S    = 1;
   localparam longint SECOND_CYCLES_DF = SECOND_TICK_S * CLK_HZ;

endpackage : input_conditioning_pkg

`default_nettype wire

/* logic/occupancy_hold_timer.sv */
`default_nettype none

module occupancy_hold_timer
   import input_conditioning_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 nrst_i,
   input  wire logic                 motion_i,
   input  wire logic                 tick_i,
   input  wire logic [REG_WIDTH-1:0] hold_seconds_i,
   output logic                      active_o
);

   logic [REG_WIDTH-1:0] remain_ff;
   logic                 active_ff;

   // Motion reloads the full hold time; each seconds tick counts one down.
   // The first tick after motion may come early, so the light stays on between
   // hold-1 and hold seconds after the last motion is seen.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         remain_ff <= '0;
      end
      else if (motion_i)
      begin
         remain_ff <= hold_seconds_i;
      end
      else if (tick_i && (remain_ff != '0))
      begin
         remain_ff <= remain_ff - 16'h0001;
      end
   end

   // Active while motion is present or the hold time has not run out.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         active_ff <= 1'b0;
      end
      else
      begin
         active_ff <= motion_i || (remain_ff > 16'h0001) || ((remain_ff == 16'h0001) && !tick_i);
      end
   end

   assign active_o = active_ff;

endmodule // occupancy_hold_timer

`default_nettype wire

/* tb/regs_asserts.sv */
`default_nettype none

module regs_asserts
   import input_conditioning_pkg::*;
(
   input wire logic                    clk_i,
   input wire logic                    nrst_i,
   input wire logic                    bus1_lit_state_i,
   input wire logic [15:0]             reg_addr_i,
   input wire logic                    reg_wr_i,
   input wire logic                    reg_rd_i,
   input wire logic [REG_WIDTH-1:0]    reg_wdata_i,
   input wire logic [REG_WIDTH-1:0]    reg_rdata_o,
   input wire logic                    reg_ack_o,
   input wire logic                    reg_err_o,
   input wire logic [SWITCH_COUNT-1:0] switch_level_o,
   input wire logic [SWITCH_COUNT-1:0] switch_change_o,
   input wire logic                    bus1_all_off_strobe_o,
   input wire logic                    bus1_recall_scene_strobe_o
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   // A write to the lighting command register, the only cause of a strobe.
   wire logic lw = reg_wr_i && (reg_addr_i == LIGHTING_BUS_COMMAND_ADDR);
   wire logic ro = reg_addr_i inside {SWITCH_INPUT_LEVELS_ADDR, OCCUPANCY_RAW_LEVELS_ADDR,
                                      OCCUPANCY_FILTERED_LEVELS_ADDR};

   // Every request gets exactly one answer, one cycle later, and nothing else answers.
   a_answer_once: assert property ((reg_rd_i || reg_wr_i) |=> (reg_ack_o != reg_err_o)) else $error("no single answer");
   a_no_spare: assert property (!(reg_rd_i || reg_wr_i) |=> !(reg_ack_o || reg_err_o)) else $error("spare answer");
   a_ro_refused: assert property (reg_wr_i && ro |=> reg_err_o) else $error("status write taken");
   a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 16'h0000 |=> reg_err_o && reg_rdata_o == 16'h0000)
      else $error("unmapped read");
   a_rdata_kept: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
   a_off_clear: assert property (lw && bus1_lit_state_i && !reg_wdata_i[0] |=> bus1_all_off_strobe_o)
      else $error("off strobe missing");
   a_recall_set: assert property (lw && !bus1_lit_state_i && reg_wdata_i[0] && !reg_wdata_i[2]
      |=> bus1_recall_scene_strobe_o) else $error("recall strobe missing");
   a_strobe_cause: assert property (bus1_all_off_strobe_o || bus1_recall_scene_strobe_o |-> $past(lw))
      else $error("strobe without write");
   a_change_marks: assert property (switch_change_o == (switch_level_o ^ $past(switch_level_o)))
      else $error("change pulse wrong");

   c_off: cover property (bus1_all_off_strobe_o);
   c_recall: cover property (bus1_recall_scene_strobe_o);
   c_refused: cover property (reg_err_o);
endmodule // regs_asserts

bind input_override_occupancy_regs regs_asserts i_asserts (.clk_i, .nrst_i, .bus1_lit_state_i, .reg_addr_i,
   .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .reg_err_o, .switch_level_o, .switch_change_o,
   .bus1_all_off_strobe_o, .bus1_recall_scene_strobe_o);

`default_nettype wire

/* tb/field_master.sv */
`default_nettype none

module field_master
(
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic        err_i,
   output logic      [15:0] addr_o,
   output logic             wr_o,
   output logic             rd_o,
   output logic      [15:0] wdata_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus at time zero.
   initial
   begin
      addr_o = 16'h0000;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 16'h0000;
   end

   // One pulse request per call. The strobe stands for the single taking edge, since a second
   // edge would be a second request; address and data stand until the answer is sampled.
   // Released lines then show the inverse, so stale values never look valid.
   task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d, output logic late);
      @(posedge clk_i);
      wr_o <= w;
      rd_o <= !w;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      late = 1'b1;
      for (int n = 0; n < 4 && late; n++)
      begin
         @(posedge clk_i);
         late = !(ack_i === 1'b1 || err_i === 1'b1);
      end
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
endmodule // field_master

`default_nettype wire

/* tb/tb.sv */
`default_nettype none

module tb
   import input_conditioning_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic              clk_i = 1'b0;
   logic              nrst_i = 1'b0;
   logic        [3:0] sw = 4'h0;
   logic        [1:0] occ = 2'b00;
   logic              lit = 1'b0;
   wire logic  [15:0] addr, wdata, rdata;
   wire logic         wr, rd, ack, err, off_s, rec_s;
   wire logic   [3:0] lvl, chg;
   wire logic   [1:0] act;
   logic       [17:0] exp_q[$];
   logic       [17:0] e;
   logic              late;
   logic        [3:0] v;
   int                fail_count = 0;
   int                checked = 0;
   int                n_off = 0;
   int                n_rec = 0;
   int                eo = 0;
   int                er = 0;

   always #10 clk_i = ~clk_i;

   input_override_occupancy_regs #(.SECOND_CYCLES(10)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i),
      .switch_input_i(sw), .occupancy_input_i(occ), .bus1_lit_state_i(lit), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_err_o(err),
      .switch_level_o(lvl), .switch_change_o(chg), .occupancy_active_o(act), .bus1_all_off_strobe_o(off_s),
      .bus1_recall_scene_strobe_o(rec_s));
   field_master i_master (.clk_i(clk_i), .ack_i(ack), .err_i(err), .addr_o(addr), .wr_o(wr), .rd_o(rd),
      .wdata_o(wdata));

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
      begin
         $display("Regression OK");
      end
      else
      begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic cmp(input string what, input logic [15:0] exp_v, input logic [15:0] got);
      checked++;
      if (got !== exp_v)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp_v, got);
      end
   endtask

   // Each access notes its expected answer; for reads d is the expected data.
   task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d, input logic ex_err, input logic chk);
      exp_q.push_back({ex_err, chk, d});
      i_master.access(w, a, d, late);
      if (late)
      begin
         fail_count++;
         end_of_test();
      end
   endtask

   // Lighting write; strobe totals are compared after the strobe cycle has closed.
   task automatic lw(input logic [15:0] d, input int add_off, input int add_rec);
      eo += add_off;
      er += add_rec;
      xfer(1'b1, LIGHTING_BUS_COMMAND_ADDR, d, 1'b0, 1'b0);
      @(posedge clk_i);
      cmp("off_count", 16'(eo), 16'(n_off));
      cmp("recall_count", 16'(er), 16'(n_rec));
   endtask

   // Every answer takes the oldest note off the queue.
   always @(negedge clk_i)
   begin
      if (ack === 1'b1 || err === 1'b1)
      begin
         e = exp_q.pop_front();
         cmp("answer_err", {15'h0000, e[17]}, {15'h0000, err});
         if (e[16] === 1'b1)
         begin
            cmp("rdata", e[15:0], rdata);
         end
      end
   end

   // Strobes are counted, so a missing or an extra pulse both show.
   always @(posedge clk_i)
   begin
      n_off <= n_off + int'(off_s === 1'b1);
      n_rec <= n_rec + int'(rec_s === 1'b1);
   end

   // A hang ends the run as a failure.
   initial
   begin
      #1_000_000;
      fail_count++;
      end_of_test();
   end

   initial
   begin
      v = 4'($urandom(78));
      repeat (4) @(posedge clk_i);
      nrst_i <= 1'b1;
      xfer(1'b0, 16'h9CA5, 16'h0000, 1'b0, 1'b1);
      xfer(1'b0, 16'h9CA6, 16'h0000, 1'b0, 1'b1);
      xfer(1'b0, 16'h9CA7, 16'h0006, 1'b0, 1'b1);
      xfer(1'b0, 16'h9CA8, 16'h0006, 1'b0, 1'b1);
      xfer(1'b0, 16'h9CAB, 16'h012C, 1'b0, 1'b1);
      xfer(1'b0, 16'h9CAC, 16'h012C, 1'b0, 1'b1);
      xfer(1'b0, 16'h0000, 16'h0000, 1'b1, 1'b1);
      xfer(1'b1, 16'h7559, 16'h000F, 1'b1, 1'b0);
      xfer(1'b1, 16'h755B, 16'h0003, 1'b1, 1'b0);
      xfer(1'b1, 16'h75C4, 16'h0003, 1'b1, 1'b0);
      $display("Test reset and refusals done");
      for (int i = 0; i < 4; i++)
      begin
         v = 4'($urandom());
         sw <= v;
         repeat (4) @(posedge clk_i);
         xfer(1'b0, 16'h7559, {12'h000, v}, 1'b0, 1'b1);
         cmp("switch_level", {12'h000, v}, {12'h000, lvl});
      end
      v = ~v;
      xfer(1'b1, 16'h9CA5, {12'h000, v}, 1'b0, 1'b0);
      cmp("forced_level", {12'h000, v}, {12'h000, lvl});
      cmp("switch_change", 16'h000F, {12'h000, chg});
      xfer(1'b0, 16'h9CA5, {12'h000, v}, 1'b0, 1'b1);
      sw <= v;
      xfer(1'b1, 16'h9CA6, 16'h000F, 1'b0, 1'b0);
      sw <= ~v;
      repeat (5) @(posedge clk_i);
      xfer(1'b1, 16'h9CA5, {12'h000, ~v}, 1'b0, 1'b0);
      cmp("locked_level", {12'h000, v}, {12'h000, lvl});
      cmp("locked_change", 16'h0000, {12'h000, chg});
      xfer(1'b1, 16'h9CA6, 16'h0000, 1'b0, 1'b0);
      sw <= v;
      repeat (4) @(posedge clk_i);
      sw <= ~v;
      repeat (5) @(posedge clk_i);
      cmp("unlocked_level", {12'h000, ~v}, {12'h000, lvl});
      $display("Test switches done");
      xfer(1'b1, 16'h9CA7, 16'h0005, 1'b0, 1'b0);
      xfer(1'b0, 16'h9CA7, 16'h0005, 1'b0, 1'b1);
      xfer(1'b1, 16'h9CAB, 16'h0003, 1'b0, 1'b0);
      xfer(1'b1, 16'h9CAC, 16'h0000, 1'b0, 1'b0);
      occ <= 2'b11;
      repeat (5) @(posedge clk_i);
      xfer(1'b0, 16'h755B, 16'h0003, 1'b0, 1'b1);
      xfer(1'b0, 16'h75C4, 16'h0001, 1'b0, 1'b1);
      cmp("occupancy_active", 16'h0001, {14'h0000, act});
      occ <= 2'b00;
      repeat (15) @(posedge clk_i);
      xfer(1'b0, 16'h75C4, 16'h0003, 1'b0, 1'b1);
      repeat (30) @(posedge clk_i);
      xfer(1'b0, 16'h75C4, 16'h0002, 1'b0, 1'b1);
      cmp("occupancy_active", 16'h0002, {14'h0000, act});
      $display("Test occupancy done");
      lit <= 1'b1;
      lw(16'h0000, 1, 0);
      lit <= 1'b0;
      lw(16'h0001, 0, 1);
      xfer(1'b0, 16'h9D3D, 16'h0000, 1'b0, 1'b1);
      lit <= 1'b1;
      lw(16'h0003, 0, 1);
      lw(16'h0005, 1, 0);
      xfer(1'b0, 16'h9D3D, 16'h0005, 1'b0, 1'b1);
      lw(16'h0001, 0, 0);
      $display("Test lighting done");
      end_of_test();
   end
endmodule // tb

`default_nettype wire
